// File: pkg/ttb_pkg.sv
// Constants, register map and helpers of the transmit system bus port.
package ttb_pkg;
	localparam logic [8:0] ADDR_SYNC_DIR = 9'h018;
	localparam logic [8:0] ADDR_FRAMING = 9'h072;
	localparam logic [8:0] ADDR_BUS_CFG = 9'h0D0;
	localparam logic [8:0] ADDR_BUS_IF = 9'h0D4;
	localparam logic [8:0] ADDR_SYNC_OFS = 9'h0D5;
	localparam logic [8:0] ADDR_CHAN_BASE = 9'h0E0;
	localparam logic [8:0] ADDR_SIG_BASE = 9'h120;
	localparam logic [8:0] ADDR_SLIP_BASE = 9'h140;
	localparam logic [8:0] ADDR_SLIP_LAST = 9'h17F;
	localparam int SD_FRAME_IN = 0;
	localparam int SD_MF_IN = 1;
	localparam int FR_FBIT_INS = 0;
	localparam int FR_FRAMER_EN = 1;
	localparam int BC_EMBEDDED_FBIT_SELECT = 0;
	localparam int BC_E1 = 1;
	localparam int BC_RATE = 2;
	localparam int BI_SLIP = 0;
	localparam int BI_DATA_NEG = 1;
	localparam int BI_SYNC_NEG = 2;
	localparam int BI_CLK_X2 = 3;
	localparam int BI_GROUP = 4;
	localparam int CC_MARK = 0;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam int FRAME_TIME_NS = 125000;
	localparam int MF_TIME_NS = 6000000;
	localparam logic [5:0] MF_FRAMES = 6'(MF_TIME_NS / FRAME_TIME_NS);
	localparam logic [11:0] T1_FRAME_BITS = 12'h0C1;
	localparam logic [11:0] E1_FRAME_BITS = 12'h100;
	localparam logic [6:0] T1_SLOTS = 7'h18;
	localparam logic [6:0] E1_SLOTS = 7'h20;
	localparam logic [7:0] FAS_WORD = 8'h1B;
	localparam logic [2:0] FAS_LAST_BIT = 3'h7;

	function automatic logic [1:0] busRate(input logic [7:0] cfg);
		return (cfg[BC_RATE+:2] == 2'h3) ? 2'h2 : cfg[BC_RATE+:2];
	endfunction

	function automatic logic [11:0] frameBits(input logic [7:0] cfg);
		if (!cfg[BC_E1] && busRate(cfg) == 2'h0) begin
			return T1_FRAME_BITS;
		end
		return E1_FRAME_BITS << busRate(cfg);
	endfunction
endpackage

// File: design/ttb_slot_shift.sv
// Serial to byte shifter for the slot data and signaling inputs.
`timescale 1ns/10ps
`default_nettype none
module ttb_slot_shift (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial bits
	input wire logic shiftEn,
	input wire logic dataBit,
	input wire logic sigBit,
	// Bytes including the current bit, first bit in the MSB
	output logic [7:0] dataByte,
	output logic [7:0] sigByte
);
	typedef struct packed {
		logic [7:0] dataSh;
		logic [7:0] sigSh;
	} ttb_shift_t;
	ttb_shift_t s_r;
	ttb_shift_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		dataByte = {s_r.dataSh[6:0], dataBit};
		sigByte = {s_r.sigSh[6:0], sigBit};
		if (shiftEn) begin
			s_nxt.dataSh = dataByte;
			s_nxt.sigSh = sigByte;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// File: design/ttb_byte_ram.sv
// Byte buffer with a bus write port, a processor port and a second read port.
`timescale 1ns/10ps
`default_nettype none
module ttb_byte_ram #(
	parameter int AW = 5
) (
	// Clock
	input wire logic clk_sys,
	// Bus side write, wins over the processor
	input wire logic busWe,
	input wire logic [AW-1:0] busAddr,
	input wire logic [7:0] busData,
	// Processor side
	input wire logic cpuWe,
	input wire logic [AW-1:0] cpuAddr,
	input wire logic [7:0] cpuData,
	output logic [7:0] cpuRdData,
	// Second read port
	input wire logic [AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [2**AW];

	always_ff @(posedge clk_sys) begin
		if (busWe) begin
			mem[busAddr] <= busData;
		end else if (cpuWe) begin
			mem[cpuAddr] <= cpuData;
		end
	end

	assign cpuRdData = mem[cpuAddr];
	assign rdData = mem[rdAddr];
endmodule
`default_nettype wire

// File: design/ttb_port.sv
// Transmit system bus port: timebase, sync pins, slot capture and registers.
`timescale 1ns/10ps
`default_nettype none
module ttb_port (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Processor register port
	input wire logic [8:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// System bus pins
	input wire logic busClockIn,
	input wire logic busSlotDataIn,
	input wire logic busSignalingIn,
	output logic slotMarkerOut,
	input wire logic frameSyncIn,
	output logic frameSyncOut,
	output logic frameSyncOe,
	input wire logic mfSyncIn,
	output logic mfSyncOut,
	output logic mfSyncOe,
	// Line side
	input wire logic [5:0] lineSlot,
	output logic [7:0] lineByte,
	output logic fbitOut,
	output logic fbitStrobe,
	output logic fbitInsertEn
);
	typedef struct packed {
		logic clkPrev;
		logic divTog;
		logic fsPrev;
		logic msPrev;
		logic [11:0] bitCnt;
		logic [5:0] frmCnt;
		logic [7:0] hunt;
		logic [7:0] syncDir;
		logic [7:0] framing;
		logic [7:0] busCfg;
		logic [7:0] busIf;
		logic [7:0] syncOfs;
		logic [31:0][7:0] chanCtl;
		logic fsOut;
		logic msOut;
		logic mark;
		logic fbit;
		logic fbitStb;
		logic [7:0] rdData;
		logic [7:0] lineByte;
	} ttb_state_t;
	ttb_state_t s_r;
	ttb_state_t s_nxt;

	logic rise;
	logic fall;
	logic dataRaw;
	logic dataEdge;
	logic syncEdge;
	logic x2;
	logic t1Fbit;
	logic [1:0] rate;
	logic [11:0] pos;
	logic [8:0] slot;
	logic [1:0] grp;
	logic [6:0] chan;
	logic inSlot;
	logic lastBit;
	logic fsIn;
	logic msIn;
	logic fsRise;
	logic msRise;
	logic atOfs;
	logic [11:0] alignCnt;
	logic [7:0] dataByte;
	logic [7:0] sigByte;
	logic slipWe;
	logic sigWe;
	logic [5:0] slipAddr;
	logic [7:0] slipCpu;
	logic [7:0] sigCpu;
	logic [7:0] slipLine;
	logic cpuSlip;
	logic cpuSig;
	logic cpuChan;

	ttb_slot_shift u_shift (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.shiftEn(dataEdge && inSlot),
		.dataBit(busSlotDataIn),
		.sigBit(busSignalingIn),
		.dataByte(dataByte),
		.sigByte(sigByte)
	);

	ttb_byte_ram #(.AW(6)) u_slip (
		.clk_sys(clk_sys),
		.busWe(slipWe),
		.busAddr(slipAddr),
		.busData(dataByte),
		.cpuWe(regWrEn && cpuSlip),
		.cpuAddr(regAddr[5:0]),
		.cpuData(regWrData),
		.cpuRdData(slipCpu),
		.rdAddr(lineSlot),
		.rdData(slipLine)
	);

	ttb_byte_ram #(.AW(5)) u_sig (
		.clk_sys(clk_sys),
		.busWe(sigWe),
		.busAddr(chan[4:0]),
		.busData({4'h0, sigByte[3:0]}),
		.cpuWe(regWrEn && cpuSig),
		.cpuAddr(regAddr[4:0]),
		.cpuData(regWrData),
		.cpuRdData(sigCpu),
		.rdAddr(5'h00),
		.rdData()
	);

	// ==========================================================
	// Bus clock edges and timebase
	always_comb begin
		s_nxt = s_r;
		s_nxt.clkPrev = busClockIn;
		rise = busClockIn && !s_r.clkPrev;
		fall = !busClockIn && s_r.clkPrev;
		x2 = s_r.busIf[ttb_pkg::BI_CLK_X2];
		dataRaw = s_r.busIf[ttb_pkg::BI_DATA_NEG] ? fall : rise;
		if (dataRaw) begin
			s_nxt.divTog = !s_r.divTog;
		end
		dataEdge = dataRaw && (!x2 || s_r.divTog);
		syncEdge = (s_r.busIf[ttb_pkg::BI_SYNC_NEG] ? fall : rise) && (!x2 || s_r.divTog);
		rate = ttb_pkg::busRate(s_r.busCfg);
		t1Fbit = !s_r.busCfg[ttb_pkg::BC_E1] && rate == 2'h0;
		pos = t1Fbit ? s_r.bitCnt - 12'h001 : s_r.bitCnt;
		slot = pos[11:3];
		grp = slot[1:0] & ((2'h1 << rate) - 2'h1);
		chan = 7'(slot >> rate);
		// Only the selected group's slots are taken; the rest pass by.
		inSlot = !(t1Fbit && s_r.bitCnt == 12'h000)
			&& grp == (s_r.busIf[ttb_pkg::BI_GROUP+:2] & ((2'h1 << rate) - 2'h1))
			&& chan < (s_r.busCfg[ttb_pkg::BC_E1] ? ttb_pkg::E1_SLOTS : ttb_pkg::T1_SLOTS);
		lastBit = pos[2:0] == 3'h7;
		fsIn = s_r.syncDir[ttb_pkg::SD_FRAME_IN];
		msIn = s_r.syncDir[ttb_pkg::SD_MF_IN];
		fsRise = syncEdge && fsIn && frameSyncIn && !s_r.fsPrev;
		msRise = syncEdge && msIn && mfSyncIn && !s_r.msPrev;
		atOfs = s_r.bitCnt == {4'h0, s_r.syncOfs};
		// The sync edge samples the offset bit itself, so the count resumes one bit past it.
		alignCnt = ({4'h0, s_r.syncOfs} >= ttb_pkg::frameBits(s_r.busCfg) - 12'h001) ? 12'h000
			: {4'h0, s_r.syncOfs} + 12'h001;
		slipWe = dataEdge && inSlot && lastBit;
		// Two-frame mode alternates buffer halves per frame; single mode uses one half.
		slipAddr = {s_r.busIf[ttb_pkg::BI_SLIP] & s_r.frmCnt[0], chan[4:0]};
		sigWe = slipWe && s_r.frmCnt == 6'h00;
		if (syncEdge) begin
			s_nxt.fsPrev = frameSyncIn;
			s_nxt.msPrev = mfSyncIn;
		end
		if (dataEdge) begin
			s_nxt.hunt = {s_r.hunt[6:0], busSlotDataIn};
			if (s_r.bitCnt >= ttb_pkg::frameBits(s_r.busCfg) - 12'h001) begin
				s_nxt.bitCnt = 12'h000;
				s_nxt.frmCnt = (s_r.frmCnt >= ttb_pkg::MF_FRAMES - 6'h01) ? 6'h00
					: s_r.frmCnt + 6'h01;
			end else begin
				s_nxt.bitCnt = s_r.bitCnt + 12'h001;
			end
			if (s_r.framing[ttb_pkg::FR_FRAMER_EN] && !fsIn && !msIn
				&& s_r.busCfg[ttb_pkg::BC_E1]
				&& {s_r.hunt[6:0], busSlotDataIn} == ttb_pkg::FAS_WORD
				&& pos[2:0] != ttb_pkg::FAS_LAST_BIT) begin
				s_nxt.bitCnt = 12'(ttb_pkg::FAS_LAST_BIT) + 12'h001;
			end
			s_nxt.mark = inSlot && s_r.chanCtl[chan[4:0]][ttb_pkg::CC_MARK];
		end
		// An input sync edge wins over the normal count in the same cycle.
		if (msRise) begin
			s_nxt.bitCnt = alignCnt;
			s_nxt.frmCnt = 6'h00;
		end else if (fsRise) begin
			s_nxt.bitCnt = alignCnt;
		end
		if (syncEdge) begin
			s_nxt.fsOut = !fsIn && atOfs;
			s_nxt.msOut = !msIn && atOfs && s_r.frmCnt == 6'h00;
		end

		// ==========================================================
		// F-bit extraction
		s_nxt.fbitStb = 1'b0;
		if (dataEdge) begin
			if (s_r.busCfg[ttb_pkg::BC_EMBEDDED_FBIT_SELECT] ? (inSlot && chan == 7'h00 && pos[2:0] == 3'h0)
				: (t1Fbit && s_r.bitCnt == 12'h000)) begin
				s_nxt.fbit = busSlotDataIn;
				s_nxt.fbitStb = 1'b1;
			end
		end

		// ==========================================================
		// Register port
		cpuChan = regAddr >= ttb_pkg::ADDR_CHAN_BASE && regAddr < ttb_pkg::ADDR_SIG_BASE;
		cpuSig = regAddr >= ttb_pkg::ADDR_SIG_BASE && regAddr < ttb_pkg::ADDR_SLIP_BASE;
		cpuSlip = regAddr >= ttb_pkg::ADDR_SLIP_BASE && regAddr <= ttb_pkg::ADDR_SLIP_LAST;
		if (regWrEn) begin
			case (regAddr)
				ttb_pkg::ADDR_SYNC_DIR: s_nxt.syncDir = regWrData;
				ttb_pkg::ADDR_FRAMING: s_nxt.framing = regWrData;
				ttb_pkg::ADDR_BUS_CFG: s_nxt.busCfg = regWrData;
				ttb_pkg::ADDR_BUS_IF: s_nxt.busIf = regWrData;
				ttb_pkg::ADDR_SYNC_OFS: s_nxt.syncOfs = regWrData;
				default: begin
					if (cpuChan) begin
						s_nxt.chanCtl[regAddr[4:0]] = regWrData;
					end
				end
			endcase
		end
		if (regRdEn) begin
			case (regAddr)
				ttb_pkg::ADDR_SYNC_DIR: s_nxt.rdData = s_r.syncDir;
				ttb_pkg::ADDR_FRAMING: s_nxt.rdData = s_r.framing;
				ttb_pkg::ADDR_BUS_CFG: s_nxt.rdData = s_r.busCfg;
				ttb_pkg::ADDR_BUS_IF: s_nxt.rdData = s_r.busIf;
				ttb_pkg::ADDR_SYNC_OFS: s_nxt.rdData = s_r.syncOfs;
				default: begin
					s_nxt.rdData = cpuChan ? s_r.chanCtl[regAddr[4:0]]
						: cpuSig ? sigCpu : cpuSlip ? slipCpu : 8'h00;
				end
			endcase
		end
		s_nxt.lineByte = slipLine;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.syncDir <= ttb_pkg::RST_REG;
			s_r.framing <= ttb_pkg::RST_REG;
			s_r.busCfg <= ttb_pkg::RST_REG;
			s_r.busIf <= ttb_pkg::RST_REG;
			s_r.syncOfs <= ttb_pkg::RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			frameSyncOe <= 1'b1;
			mfSyncOe <= 1'b1;
		end else begin
			frameSyncOe <= !s_nxt.syncDir[ttb_pkg::SD_FRAME_IN];
			mfSyncOe <= !s_nxt.syncDir[ttb_pkg::SD_MF_IN];
		end
	end
	assign regRdData = s_r.rdData;
	assign slotMarkerOut = s_r.mark;
	assign frameSyncOut = s_r.fsOut;
	assign mfSyncOut = s_r.msOut;
	assign lineByte = s_r.lineByte;
	assign fbitOut = s_r.fbit;
	assign fbitStrobe = s_r.fbitStb;
	assign fbitInsertEn = s_r.framing[ttb_pkg::FR_FBIT_INS];

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_fsAlign;
		fsRise && !msRise;
	endsequence
	sequence s_msAlign;
		msRise;
	endsequence

	property p_fsOfs;
		$rose(frameSyncOut) |-> $past(atOfs) && $past(syncEdge);
	endproperty
	a_fsOfs: assert property (p_fsOfs) else $error("frame sync not at offset bit");

	property p_msWithFs;
		mfSyncOut && frameSyncOe |-> frameSyncOut;
	endproperty
	a_msWithFs: assert property (p_msWithFs) else $error("multiframe sync without frame sync");

	property p_inNoDrive;
		s_r.syncDir[ttb_pkg::SD_FRAME_IN] |-> !frameSyncOe;
	endproperty
	a_inNoDrive: assert property (p_inNoDrive) else $error("frame sync driven as input");

	property p_fsAlign;
		s_fsAlign |=> s_r.bitCnt == $past(alignCnt);
	endproperty
	a_fsAlign: assert property (p_fsAlign) else $error("frame sync did not align");

	property p_msAlign;
		s_msAlign |=> s_r.frmCnt == 6'h00 && s_r.bitCnt == $past(alignCnt);
	endproperty
	a_msAlign: assert property (p_msAlign) else $error("multiframe sync did not align");

	property p_counters;
		s_r.frmCnt < ttb_pkg::MF_FRAMES;
	endproperty
	a_counters: assert property (p_counters) else $error("frame counter out of range");

	property p_sigFrame0;
		sigWe |-> s_r.frmCnt == 6'h00 && dataEdge;
	endproperty
	a_sigFrame0: assert property (p_sigFrame0) else $error("signaling taken outside frame zero");

	property p_markEdge;
		$changed(slotMarkerOut) |-> $past(dataEdge);
	endproperty
	a_markEdge: assert property (p_markEdge) else $error("marker changed off data edge");

	property p_div2;
		x2 && dataEdge && !regWrEn |=> !dataEdge;
	endproperty
	a_div2: assert property (p_div2) else $error("double rate edges not divided");
endmodule
`default_nettype wire

// File: dv/ttb_sys_model.sv
// System side bus model feeding slot data, signaling and sync pulses.
`timescale 1ns/10ps
`default_nettype none
module ttb_sys_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sync pulse enables
	input wire logic fsEn,
	input wire logic msEn,
	// Bus pins towards the port
	output logic busClk,
	output logic dataBit,
	output logic sigBit,
	output logic fsync,
	output logic msync,
	output logic [7:0] bitIdx
);
	// ==========
	// Bus timing
	logic [1:0] div_r;
	logic [7:0] slotByte;
	logic [7:0] sigByte;
	// Bits move on the falling bus edge so they are steady at the rising one.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 2'h0;
			busClk <= 1'b0;
			bitIdx <= 8'hFF;
		end else begin
			div_r <= div_r + 2'h1;
			if (div_r == 2'h3) begin
				busClk <= !busClk;
				if (busClk) begin
					bitIdx <= bitIdx + 8'h01;
				end
			end
		end
	end
	assign slotByte = 8'hA0 ^ {3'h0, bitIdx[7:3]};
	assign sigByte = {4'h5, bitIdx[6:3]};
	assign dataBit = slotByte[3'h7 - bitIdx[2:0]];
	assign sigBit = sigByte[3'h7 - bitIdx[2:0]];
	assign fsync = fsEn && (bitIdx == 8'h00);
	assign msync = msEn && (bitIdx == 8'h00);
endmodule
`default_nettype wire

// File: dv/tdm_transmit_system_bus_port_tb_top.sv
// Self-checking bench for the transmit system bus port.
`timescale 1ns/10ps
`default_nettype none
module tdm_transmit_system_bus_port_tb_top;
	// ==========
	// Signals
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [8:0] regAddr = 9'h000;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic [5:0] lineSlot = 6'h00;
	logic [7:0] lineByte;
	logic fsEn = 1'b0;
	logic msEn = 1'b0;
	logic busClk, dataBit, sigBit, pFs, pMs, marker, fsOut, fsOe, msOut, msOe, fbitIns, fsWire, msWire;
	logic [7:0] bitIdx;
	int errTotal = 0;
	int checksDone = 0;
	// The pin level is whoever drives it; the model only drives when asked.
	assign fsWire = fsOe ? fsOut : pFs;
	assign msWire = msOe ? msOut : pMs;
	ttb_sys_model sysSide (.clk_sys(clk_sys), .rst_n(rst_n), .fsEn(fsEn), .msEn(msEn), .busClk(busClk),
		.dataBit(dataBit), .sigBit(sigBit), .fsync(pFs), .msync(pMs), .bitIdx(bitIdx));
	ttb_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regWrData(regWrData), .regRdData(regRdData), .busClockIn(busClk), .busSlotDataIn(dataBit),
		.busSignalingIn(sigBit), .slotMarkerOut(marker), .frameSyncIn(fsWire), .frameSyncOut(fsOut),
		.frameSyncOe(fsOe), .mfSyncIn(msWire), .mfSyncOut(msOut), .mfSyncOe(msOe), .lineSlot(lineSlot),
		.lineByte(lineByte), .fbitOut(), .fbitStrobe(), .fbitInsertEn(fbitIns));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ==========
	// Helpers
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string msg);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %0t %s: got %h want %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		@(posedge clk_sys);
		d = regRdData;
	endtask
	task automatic measure();
		int n;
		n = 0;
		@(negedge clk_sys);
		while (fsOut === 1'b1) @(negedge clk_sys);
		while (fsOut !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		cmp(12'(bitIdx), 12'h000, "sync position");
		n = 0;
		while (fsOut === 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		cmp(12'(n), 12'h008, "sync width");
		while (fsOut !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		cmp(12'(n), 12'h800, "frame period");
		@(posedge clk_sys);
	endtask
	// ==========
	// Tests
	task automatic test_regs();
		logic [7:0] d;
		wr(9'h0D5, 8'h05);
		rd(9'h0D5, d);
		cmp(12'(d), 12'h005, "offset readback");
		rd(9'h1FF, d);
		cmp(12'(d), 12'h000, "unmapped read");
		wr(9'h072, 8'h01);
		cmp(12'(fbitIns), 12'h001, "insert enable");
		wr(9'h018, 8'h03);
		cmp({10'h000, fsOe, msOe}, 12'h000, "sync pins in");
		wr(9'h072, 8'h00);
		$display("test regs done");
	endtask
	task automatic test_sync_in(input logic [7:0] dir, input logic [7:0] ofs);
		wr(9'h0D5, ofs);
		wr(9'h018, dir);
		cmp({10'h000, fsOe, msOe}, {10'h000, ~dir[0], ~dir[1]}, "pin direction");
		fsEn <= dir[0];
		msEn <= dir[1];
		repeat (4300) @(posedge clk_sys);
		fsEn <= 1'b0;
		msEn <= 1'b0;
		wr(9'h018, 8'h00);
		measure();
		$display("test sync input %h done", dir);
	endtask
	task automatic test_capture();
		logic [7:0] d;
		rd(9'h143, d);
		cmp(12'(d), 12'h0A3, "slot byte");
		rd(9'h123, d);
		cmp(12'(d[3:0]), 12'h003, "signaling");
		lineSlot <= 6'h03;
		repeat (3) @(posedge clk_sys);
		cmp(12'(lineByte), 12'h0A3, "line byte");
		$display("test capture done");
	endtask
	task automatic test_marker();
		int n;
		int bad;
		wr(9'h0E3, 8'h01);
		for (int e = 0; e < 2; e++) begin
			wr(9'h0D4, 8'(e * 2));
			repeat (2100) @(posedge clk_sys);
			n = 0;
			bad = 0;
			repeat (2048) begin
				@(negedge clk_sys);
				if (marker === 1'b1) begin
					n++;
					if (bitIdx < 8'h18 || bitIdx > 8'h21) begin
						bad++;
					end
				end
			end
			@(posedge clk_sys);
			cmp(12'(n), 12'h040, "marker length");
			cmp(12'(bad), 12'h000, "marker place");
		end
		wr(9'h0D4, 8'h00);
		$display("test marker done");
	endtask
	// Multiframe sync may only appear together with frame sync.
	always @(negedge clk_sys) begin
		if (rst_n && fsOe && msOe && msOut === 1'b1 && fsOut !== 1'b1) begin
			errTotal++;
			$display("[FAIL] %0t lone multiframe sync", $time);
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		errTotal++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		cmp({10'h000, fsOe, msOe}, 12'h003, "sync pins out");
		rst_n <= 1'b1;
		@(posedge clk_sys);
		test_regs();
		wr(9'h0D0, 8'h02);
		test_sync_in(8'h02, 8'h00);
		test_capture();
		test_marker();
		test_sync_in(8'h01, 8'h05);
		final_report();
	end
endmodule
`default_nettype wire
